// file: verilog/lsosc_pkg.sv
// package of constants for the slow oscillator and system clock select block
`default_nettype none
package lsosc_pkg;
   // crystal low-power select encoding and its power-up value
   localparam logic       XTAL_MODE_QUICK_START = 1'b0;
   localparam logic       XTAL_MODE_LOW_POWER   = 1'b1;
   localparam logic       XTAL_LP_RESET         = XTAL_MODE_QUICK_START;
   // system clock mode power-up values: fast source, no division
   localparam logic       HIGH_LOW_CLOCK_SEL_RESET           = 1'b1;
   localparam logic [2:0] CKS_RESET             = 3'h7;
   // divider codes: 000 and 001 pick the slow source, 010..110 fast/32..fast/2, 111 fast
   localparam logic [2:0] CKS_SLOW_MAX          = 3'h1;
   localparam logic [2:0] CKS_FAST_FULL         = 3'h7;
   // fast-source prescaler width, enough for a divide by 64
   localparam int         PRESCALE_W            = 6;
   // time base divider of the system clock
   localparam logic [1:0] TB_SYS_DIV_LAST       = 2'h3;
   // time base source select encoding
   localparam logic       TB_SRC_XTAL           = 1'b0;
   localparam logic       TB_SRC_SYS_DIV4       = 1'b1;
   // crystal frequency in Hz and default settling count in crystal periods
   localparam int         XTAL_FREQ_HZ          = 32768;
   localparam int         XTAL_STARTUP_TICKS    = 1024;
endpackage : lsosc_pkg
`default_nettype wire

// file: verilog/lsosc_tick_sync.sv
// two-stage synchroniser turning an oscillator pin into a one-cycle rising-edge tick
`default_nettype none
`timescale 1ns/100ps
module lsosc_tick_sync
   import lsosc_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // asynchronous oscillator level
   input  wire logic osc_in,
   // one-cycle pulse per rising edge
   output logic      tick
);
   logic meta_reg;   // first stage, read only by the second stage
   logic sync_reg;   // second stage, safe to use
   logic last_reg;   // previous synchronised level for the edge

   // synchroniser chain and edge history
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= osc_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // rising edge seen on the stable stages only
   assign tick = sync_reg & ~last_reg;
endmodule : lsosc_tick_sync
`default_nettype wire

// file: verilog/lsosc_clock_select.sv
// slow oscillator control, system clock selection and time base clock selection
// Notes on behaviour
// - one bit picks crystal quick-start or low-power
// - that bit clears to quick-start at power-up
// - crystal clock behaves alike in both modes
// - crystal clock unused until start-up delay ends
// - crystal is fixed-frequency time base source
// - slow RC oscillator always on after power-up
// - system clock from fast or slow source
// - time bases use crystal or system/4
`default_nettype none
`timescale 1ns/100ps
module lsosc_clock_select
   import lsosc_pkg::*;
#(
   parameter int STARTUP_TICKS = XTAL_STARTUP_TICKS   // crystal periods to settle
)(
   // clock and reset; clk is the fast source
   input  wire logic       clk,
   input  wire logic       rst_b,
   // oscillator pins, asynchronous
   input  wire logic       xtal_osc_in,
   input  wire logic       slow_rc_osc_in,
   // crystal low-power select write port
   input  wire logic       xtal_lp_wr,
   input  wire logic       xtal_lp_wdata,
   // system clock mode write port
   input  wire logic       sysclk_mode_wr,
   input  wire logic       high_low_clock_sel_wdata,
   input  wire logic [2:0] clock_divider_sel_wdata,
   // time base source selects, one per time base
   input  wire logic       tb0_src_sel,
   input  wire logic       tb1_src_sel,
   // oscillator controls
   output logic            xtal_low_power_sel,
   output logic            int_slow_rc_osc_en,
   // status
   output logic            xtal_ready,
   output logic            high_low_clock_sel,
   output logic [2:0]      clock_divider_sel,
   // clock enables
   output logic            sysclk_en,
   output logic            tb0_clk_en,
   output logic            tb1_clk_en
);
   // counter wide enough to hold the settle count itself
   localparam int CNT_W = $clog2(STARTUP_TICKS + 1);

   logic                  xtal_tick;        // crystal edge pulse
   logic                  slow_tick;        // slow rc edge pulse
   logic                  xtal_lp_reg;      // crystal mode bit
   logic                  rc_en_reg;        // slow rc enable
   logic                  hl_reg;           // requested fast/slow select
   logic [2:0]            cks_reg;          // requested divider code
   logic                  act_hl_reg;       // active fast/slow select
   logic [2:0]            act_cks_reg;      // active divider code
   logic [PRESCALE_W-1:0] pre_reg;          // fast-source prescaler
   logic [PRESCALE_W-1:0] pre_next;
   logic [CNT_W-1:0]      start_reg;        // crystal settle counter
   logic                  ready_reg;        // crystal settled
   logic [1:0]            div4_reg;         // system clock divide by four
   logic                  sys_tick;         // selected system clock pulse
   logic                  sys_slow;         // active choice is slow source
   logic                  fast_tick;        // divided fast pulse
   logic [2:0]            fast_shift;       // divide exponent 5..1
   logic [PRESCALE_W-1:0] fast_mask;        // low prescaler bits to match
   logic                  sys_div4_tick;    // system clock / 4 pulse
   logic                  xtal_good_tick;   // crystal pulse after settling
   logic                  sel_pending;      // a new selection awaits a boundary
   logic                  raw_tick;         // selected source pulse before the switch gap
   logic                  act_full;         // active choice passes every fast cycle
   logic                  skip_reg;         // drop the first new-mode pulse after a switch

   // pin synchronisers
   // both pins are free-running oscillators from outside this clock domain
   lsosc_tick_sync u_xtal_sync (
      .clk    (clk),
      .rst_b  (rst_b),
      .osc_in (xtal_osc_in),
      .tick   (xtal_tick)
   );
   lsosc_tick_sync u_rc_sync (
      .clk    (clk),
      .rst_b  (rst_b),
      .osc_in (slow_rc_osc_in),
      .tick   (slow_tick)
   );

   // crystal mode bit, quick start after reset
   // no guard against low-power before the crystal settles: that order is software's duty
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         xtal_lp_reg <= XTAL_LP_RESET;
      end else if (xtal_lp_wr) begin
         xtal_lp_reg <= xtal_lp_wdata;
      end
   end
   // the mode only trims oscillator bias; ticks are used the same either way
   assign xtal_low_power_sel = xtal_lp_reg;

   // slow rc enable: set out of reset and no input can clear it
   // low only inside reset so the enable stays a plain flop; it rises at the first edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rc_en_reg <= 1'b0;
      end else begin
         rc_en_reg <= 1'b1;
      end
   end
   assign int_slow_rc_osc_en = rc_en_reg;

   // crystal settle counter, counts real crystal periods from power-up
   // limitation: a pin already high at reset release counts as a first edge, so the
   // settle time may end up to one crystal period early
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         start_reg <= '0;
         ready_reg <= 1'b0;
      end else if (!ready_reg && xtal_tick) begin
         if (start_reg == CNT_W'(STARTUP_TICKS - 1)) begin
            ready_reg <= 1'b1;
         end
         start_reg <= start_reg + 1'b1;
      end
   end
   assign xtal_ready = ready_reg;
   // a crystal edge counts only once settled; low-power before this is not guarded (software's duty)
   assign xtal_good_tick = xtal_tick & ready_reg;

   // requested system clock mode
   // readback shows the request at once; the active choice follows at a pulse boundary
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hl_reg  <= HIGH_LOW_CLOCK_SEL_RESET;
         cks_reg <= CKS_RESET;
      end else if (sysclk_mode_wr) begin
         hl_reg  <= high_low_clock_sel_wdata;
         cks_reg <= clock_divider_sel_wdata;
      end
   end
   assign high_low_clock_sel = hl_reg;
   assign clock_divider_sel  = cks_reg;

   // free-running fast prescaler
   // never cleared on a switch, so divided pulses keep a fixed phase and any window
   // of 64 cycles holds the same number of them
   assign pre_next = pre_reg + 1'b1;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_next;
      end
   end

   // source and divider decode from the active selection
   // codes 000 and 001 use the slow source, 010..110 divide the fast source by
   // 2^(7-code), 111 or a set high/low bit pass every fast cycle
   assign sys_slow   = !act_hl_reg && (act_cks_reg <= CKS_SLOW_MAX);
   assign act_full   = act_hl_reg || (act_cks_reg == CKS_FAST_FULL);
   assign fast_shift = 3'(CKS_FAST_FULL - act_cks_reg);
   assign fast_mask  = PRESCALE_W'((7'h01 << fast_shift) - 7'h01);
   assign fast_tick  = act_full ? 1'b1
                       : ((pre_reg & fast_mask) == fast_mask);
   assign raw_tick   = sys_slow ? slow_tick : fast_tick;
   // the first pulse of a new mode may land right after the last old one, so it is
   // dropped; the undivided fast source needs no gap since every cycle is a pulse there
   assign sys_tick   = raw_tick && (!skip_reg || act_full);

   // new selection takes effect only on a pulse of the old one, so no pulse is cut short
   assign sel_pending = (hl_reg != act_hl_reg) || (cks_reg != act_cks_reg);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         act_hl_reg  <= HIGH_LOW_CLOCK_SEL_RESET;
         act_cks_reg <= CKS_RESET;
      end else if (sel_pending && sys_tick) begin
         act_hl_reg  <= hl_reg;
         act_cks_reg <= cks_reg;
      end
   end

   // switch gap: set with the switch, cleared by the first raw pulse of the new mode
   // trade-off: one period of the new mode is lost on every change except into the undivided fast source, even slow to slow
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         skip_reg <= 1'b0;               // reset mode is already active
      end else if (sel_pending && sys_tick) begin
         skip_reg <= 1'b1;
      end else if (raw_tick) begin
         skip_reg <= 1'b0;               // first new pulse swallowed
      end
   end

   // system clock divided by four for the time bases
   // counts system pulses only, so the quarter rate follows any source switch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div4_reg <= '0;
      end else if (sys_tick) begin
         div4_reg <= div4_reg + 1'b1;
      end
   end
   assign sys_div4_tick = sys_tick && (div4_reg == TB_SYS_DIV_LAST);

   // registered enables
   // every enable leaves through a flop one cycle after its internal pulse, so the
   // quarter-rate time base pulse lines up with the matching sysclk_en
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sysclk_en  <= 1'b0;
         tb0_clk_en <= 1'b0;
         tb1_clk_en <= 1'b0;
      end else begin
         sysclk_en  <= sys_tick;
         tb0_clk_en <= (tb0_src_sel == TB_SRC_SYS_DIV4) ? sys_div4_tick : xtal_good_tick;
         tb1_clk_en <= (tb1_src_sel == TB_SRC_SYS_DIV4) ? sys_div4_tick : xtal_good_tick;
      end
   end
endmodule : lsosc_clock_select
`default_nettype wire

// file: tb/lsosc_osc_model.sv
// free-running oscillator model for the crystal and slow rc pins
`timescale 1ns/100ps
`default_nettype none
module lsosc_osc_model #(parameter real HALF_NS = 61.0) (
   // oscillator pin level
   output logic osc
);
   initial osc = 1'b0;
   // fixed frequency square wave, the same in either crystal mode
   always #(HALF_NS) osc = ~osc;
endmodule : lsosc_osc_model
`default_nettype wire

// file: tb/lsosc_clock_select_asserts.sv
// concurrent checks on the ports of the clock select block
`timescale 1ns/100ps
`default_nettype none
module lsosc_clock_select_asserts
   import lsosc_pkg::*;
#(
   parameter int STARTUP_TICKS = 4   // settle count of the bound instance
)(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_b,
   // oscillator pins
   input wire logic       xtal_osc_in,
   input wire logic       slow_rc_osc_in,
   // write ports
   input wire logic       xtal_lp_wr,
   input wire logic       xtal_lp_wdata,
   input wire logic       sysclk_mode_wr,
   input wire logic       high_low_clock_sel_wdata,
   input wire logic [2:0] clock_divider_sel_wdata,
   // time base selects
   input wire logic       tb0_src_sel,
   input wire logic       tb1_src_sel,
   // oscillator controls and status
   input wire logic       xtal_low_power_sel,
   input wire logic       int_slow_rc_osc_en,
   input wire logic       xtal_ready,
   input wire logic       high_low_clock_sel,
   input wire logic [2:0] clock_divider_sel,
   // clock enables
   input wire logic       sysclk_en,
   input wire logic       tb0_clk_en,
   input wire logic       tb1_clk_en
);
   // requested mode decode
   wire fast_full = high_low_clock_sel && clock_divider_sel == CKS_FAST_FULL;
   wire divided   = !high_low_clock_sel && clock_divider_sel != CKS_FAST_FULL;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   lp_load_a: assert property (xtal_lp_wr |=> xtal_low_power_sel == $past(xtal_lp_wdata))
      else $error("crystal mode bit not loaded");
   lp_hold_a: assert property (!xtal_lp_wr |=> $stable(xtal_low_power_sel))
      else $error("crystal mode bit changed without write");
   rc_on_a: assert property ($past(rst_b) |-> int_slow_rc_osc_en)
      else $error("slow rc oscillator not enabled");
   mode_load_a: assert property (sysclk_mode_wr |=> {high_low_clock_sel, clock_divider_sel} ==
      $past({high_low_clock_sel_wdata, clock_divider_sel_wdata})) else $error("clock mode not loaded");
   // the request must stand one sample earlier so a last old-mode pulse is not judged
   fast_every_a: assert property (fast_full [*2] ##0 (sysclk_en && !sysclk_mode_wr) |=> sysclk_en)
      else $error("fast undivided clock skipped a pulse");
   no_short_a: assert property (divided [*4] ##0 sysclk_en |=> !sysclk_en)
      else $error("shortened system clock period");
   ready_hold_a: assert property (xtal_ready |=> xtal_ready)
      else $error("crystal ready dropped");
   tb_div4_a: assert property (tb0_src_sel [*3] ##0 tb0_clk_en |-> sysclk_en)
      else $error("time base pulse off system pulse");
   tb_settle_a: assert property ((!tb1_src_sel) [*3] ##0 tb1_clk_en |-> $past(xtal_ready))
      else $error("crystal time base pulse before ready");
   cover property (divided && sysclk_en);
   cover property (tb1_clk_en);
   cover property (xtal_lp_wr && xtal_lp_wdata);
endmodule : lsosc_clock_select_asserts
bind lsosc_clock_select lsosc_clock_select_asserts #(.STARTUP_TICKS(STARTUP_TICKS)) asserts_inst (.*);
`default_nettype wire

// file: tb/lsosc_clock_select_bench.sv
// self-checking bench for the clock select block
`timescale 1ns/100ps
`default_nettype none
module lsosc_clock_select_bench import lsosc_pkg::*;;
   localparam int  WIN = 256;           // counting window in cycles, a multiple of 64
   localparam real XH = 61.0, SH = 97.0; // oscillator half periods, unrelated to clk
   localparam int  XL = $rtoi(WIN * 5.0 / (2.0 * XH)); // fewest crystal edges in a window
   logic clk = 1'b0, rst_b = 1'b0, xtal_osc_in, slow_rc_osc_in, xtal_lp_wr = 1'b0, xtal_lp_wdata = 1'b0;
   logic sysclk_mode_wr = 1'b0, high_low_clock_sel_wdata = 1'b0, tb0_src_sel = 1'b1, tb1_src_sel = 1'b0;
   logic [2:0] clock_divider_sel_wdata = 3'h0, clock_divider_sel, c;
   logic xtal_low_power_sel, int_slow_rc_osc_en, xtal_ready, high_low_clock_sel, sysclk_en, tb0_clk_en, tb1_clk_en;
   int n_errors = 0, n_tests = 0, ns, n0, n1, lo;
   always #2.5 clk = ~clk;
   lsosc_osc_model #(.HALF_NS(XH)) lsosc_osc_model_inst (.osc(xtal_osc_in));
   lsosc_osc_model #(.HALF_NS(SH)) lsosc_osc_model_rc_inst (.osc(slow_rc_osc_in));
   // short settling count keeps the run brief
   lsosc_clock_select #(.STARTUP_TICKS(4)) lsosc_clock_select_inst (.*);
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk(input int got, input int l, input int h);
      n_tests++;
      if (got < l || got > h) begin
         n_errors++;
         $display("ERROR %0t value %0d outside %0d..%0d", $time, got, l, h);
      end
   endtask : chk
   // both write ports may fire together
   task automatic wr(input logic w1, d, w2, h, input logic [2:0] c2);
      cyc(1);
      {xtal_lp_wr, xtal_lp_wdata, sysclk_mode_wr, high_low_clock_sel_wdata, clock_divider_sel_wdata} = {w1, d, w2, h, c2};
      cyc(1);
      {xtal_lp_wr, sysclk_mode_wr} = 2'h0;
      chk(int'(!w1 || xtal_low_power_sel === d), 1, 1);
      chk(int'(!w2 || {high_low_clock_sel, clock_divider_sel} === {h, c2}), 1, 1);
   endtask : wr
   task automatic count(input int n);
      {ns, n0, n1} = '0;
      repeat (n) begin
         cyc(1);
         ns += int'(sysclk_en === 1'b1);
         n0 += int'(tb0_clk_en === 1'b1);
         n1 += int'(tb1_clk_en === 1'b1);
      end
   endtask : count
   // slow codes count rc edges, fast codes divide the window exactly
   function automatic int exp_lo(input logic [2:0] k);
      if (k <= CKS_SLOW_MAX) return $rtoi(WIN * 5.0 / (2.0 * SH));
      return WIN >> (CKS_FAST_FULL - k);
   endfunction : exp_lo
   task automatic print_verdict();
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   initial begin
      #100000;
      n_errors++;
      print_verdict();
   end
   initial begin
      void'($urandom(20113));
      cyc(20);
      chk(int'({xtal_low_power_sel, high_low_clock_sel, clock_divider_sel} === {XTAL_LP_RESET, HIGH_LOW_CLOCK_SEL_RESET, CKS_RESET}), 1, 1);
      rst_b = 1'b1;
      cyc(2);
      chk(int'(int_slow_rc_osc_en === 1'b1), 1, 1);
      count(16);
      chk(ns, 16, 16);
      lo = 0;
      while (xtal_ready !== 1'b1 && lo < 2000) begin
         cyc(1);
         lo++;
      end
      chk(lo, 30, 100);
      wr(1'b1, XTAL_MODE_LOW_POWER, 1'b0, 1'b0, 3'h0);
      for (int i = 0; i < 12; i++) begin
         c = (i < 8) ? 3'(i) : 3'($urandom_range(7));
         wr(1'b1, 1'($urandom_range(1)), 1'b1, 1'b0, c);
         cyc(100);
         count(WIN);
         lo = exp_lo(c);
         chk(ns, lo, lo + int'(c <= CKS_SLOW_MAX));
         chk(n0, ns / 4, (ns + 3) / 4);
         chk(n1, XL, XL + 1);
      end
      wr(1'b0, 1'b0, 1'b1, HIGH_LOW_CLOCK_SEL_RESET, CKS_RESET);
      // swap the time base sources so each select is seen in both positions
      tb0_src_sel = TB_SRC_XTAL;
      tb1_src_sel = TB_SRC_SYS_DIV4;
      cyc(100);
      count(WIN);
      chk(ns, WIN, WIN);
      chk(n0, XL, XL + 1);
      chk(n1, WIN / 4, WIN / 4);
      print_verdict();
   end
endmodule : lsosc_clock_select_bench
`default_nettype wire
